//--- rtl/io_sampling_pkg.sv
// What this block does
// [R1] Sample enabled lines every interval milliseconds
// [R2] No periodic sampling without interval or lines
// [R3] Masked line change sends digital sample now
// [R4] Change-detect sample carries digital states only
// [R5] While sleeping, edges are not reported
// [R6] Mask bit n watches line n, 0..14
// [R7] Reference select: 0, 1, 2 legal
// [R8] Batch samples per packet, 1 to 255
// [R9] Clamp batch count to payload; reads show clamp
// [R10] Sample only every Nth wake cycle
// [R11] Divider zero: sample before sleep, every wake
// [R12] Level map write sets output lines 0..7
// [R13] Pass only from bound source, present lines
// [R14] All-ones binding disables; 0xFFFF accepts anyone
// [R15] Forward accepted samples when enable is set
// [R16] Forward only in API modes 1 or 2
// [R17] Line outputs hold passed value, then revert
// [R18] PWM duty holds for timeout, then reverts
// [R19] PWM timeout acts only in PWM mode
// [R20] Received analog channel zero drives PWM duty
// [R21] Line hold tick is 100 ms, one constant
package io_sampling_pkg;
  localparam int CLOCK_HZ          = 250_000_000;
  localparam int SAMPLE_UNIT_US    = 1000;
  localparam int MS_CYCLES         = SAMPLE_UNIT_US * (CLOCK_HZ / 1_000_000);
  localparam int HOLD_TICK_MS      = 100;
  localparam int LINE_COUNT        = 15;
  localparam int HOLD_LINES        = 13;
  localparam int ANALOG_COUNT      = 4;
  localparam int MAX_PAYLOAD_BYTES = 100;
  localparam int DIGITAL_BYTES     = 2;
  localparam int ANALOG_BYTES      = 2;
  localparam logic [7:0]  SPP_MAX       = 8'hFF;
  localparam logic [7:0]  SPP_RESET     = 8'h01;
  localparam logic [7:0]  DIVIDER_RESET = 8'h01;
  localparam logic [7:0]  PWM_HOLD_RESET = 8'hFF;
  localparam logic [1:0]  REF_MAX       = 2'h2;
  localparam logic [1:0]  API_PLAIN     = 2'h1;
  localparam logic [1:0]  API_ESCAPED   = 2'h2;
  localparam logic [63:0] BIND_DISABLED = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] BIND_ANY      = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] BIND_RESET    = 64'hFFFF_FFFF_FFFF_FFFF;

  typedef enum logic [3:0] {
    SEL_SAMPLE_INTERVAL,
    SEL_EDGE_MASK,
    SEL_REFERENCE,
    SEL_SAMPLES_PER_PACKET,
    SEL_SLEEP_DIVIDER,
    SEL_LEVEL_MAP,
    SEL_BOUND_ADDRESS,
    SEL_FORWARD_ENABLE,
    SEL_LINE_HOLD,
    SEL_PWM_HOLD
  } param_select_type;

  typedef struct packed {
    logic             write;
    param_select_type select;
    logic [3:0]       line;
    logic [63:0]      data;
  } param_cmd_type;

  typedef struct packed {
    logic        valid;
    logic [63:0] source;
    logic [14:0] digital_mask;
    logic [14:0] digital_state;
    logic        analog0_valid;
    logic [9:0]  analog0;
  } rx_sample_type;
endpackage : io_sampling_pkg

//--- rtl/io_sampling_line_passing.sv
`timescale 1ns/1ps
module io_sampling_line_passing #(
  parameter int MS_CYCLES = io_sampling_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rstn,
  // Command-mode parameter access
  input  wire io_sampling_pkg::param_cmd_type cmd,
  output logic [63:0]                        param_read_data,
  // Pin configuration and levels
  input  wire logic [14:0]                   digital_enabled,
  input  wire logic [3:0]                    analog_enabled,
  input  wire logic [12:0]                   line_is_output,
  input  wire logic [12:8]                   configured_high,
  input  wire logic [14:0]                   digital_line,
  input  wire logic [1:0]                    pwm_mode,
  input  wire logic [9:0]                    first_pwm_duty,
  input  wire logic [9:0]                    second_pwm_duty,
  input  wire logic [1:0]                    api_mode_select,
  // Sleep status
  input  wire logic                          sleep_enable,
  input  wire logic                          awake,
  input  wire logic                          wake_start,
  input  wire logic                          sleep_entry,
  // Received samples
  input  wire io_sampling_pkg::rx_sample_type rx,
  // Sampling outputs
  output logic                               sample_take,
  output logic                               packet_send,
  output logic [7:0]                         packet_sample_count,
  output logic                               change_send,
  output logic [14:0]                        change_state,
  output logic [1:0]                         converter_reference,
  // Line passing outputs
  output logic                               forward_sample,
  output logic [12:0]                        line_out,
  output logic [9:0]                         pwm_duty0,
  output logic [9:0]                         pwm_duty1
);
  import io_sampling_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic [15:0] sample_interval;
  logic [14:0] edge_monitor_mask;
  logic [7:0]  samples_per_packet;
  logic [7:0]  spp_effective;
  logic [7:0]  sleep_sample_divider;
  logic [7:0]  output_level_map;
  logic [63:0] bound_source_address;
  logic        passed_sample_forward_enable;
  logic [7:0]  line_hold [HOLD_LINES];
  logic [7:0]  pwm_hold_timeout;
  logic [17:0] ms_count;
  logic        ms_tick;
  logic [6:0]  hold_count;
  logic        hold_tick;
  logic [15:0] interval_count;
  logic [7:0]  wake_count;
  logic        wake_window;
  logic [7:0]  batch_count;
  logic [14:0] line_prev;
  logic [12:0] held;
  logic [7:0]  hold_timer [HOLD_LINES];
  logic [1:0]  pwm_held;
  logic [7:0]  pwm_timer;
  logic        accept;
  logic        periodic_on;
  logic        window_open;
  logic        periodic_fire;
  logic [12:0] base_level;
  logic [14:0] next_change;

  // Payload bytes per sample decide how many samples a packet holds
  function automatic logic [7:0] fit_count(input logic [14:0] dig, input logic [3:0] ana);
    int bytes;
    int fit;
    bytes = (|dig) ? DIGITAL_BYTES : 0;
    for (int i = 0; i < ANALOG_COUNT; i++) begin
      bytes = bytes + (ana[i] ? ANALOG_BYTES : 0);
    end
    fit = (bytes == 0) ? int'(SPP_MAX) : MAX_PAYLOAD_BYTES / bytes;
    if (fit > int'(SPP_MAX)) begin
      fit = int'(SPP_MAX);
    end
    return 8'(fit);
  endfunction : fit_count

  function automatic logic bind_match(input logic [63:0] bound, input logic [63:0] src);
    if (bound == BIND_DISABLED) begin
      return 1'b0;
    end
    return (bound == BIND_ANY) || (bound == src);
  endfunction : bind_match

  assign accept      = rx.valid && bind_match(bound_source_address, rx.source); // [R13] [R14]
  assign periodic_on = (sample_interval != '0) && ((|digital_enabled) || (|analog_enabled)); // [R2]
  assign window_open = !sleep_enable || (awake && wake_window); // [R10]
  assign periodic_fire = periodic_on && window_open && ms_tick
                         && (interval_count == sample_interval - 16'h1); // [R1]
  assign base_level  = {configured_high, output_level_map}; // [R12]
  assign next_change = (digital_line ^ line_prev) & edge_monitor_mask; // [R6]

  // Parameter writes; out-of-range values are dropped rather than clipped
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sample_interval              <= '0;
      edge_monitor_mask            <= '0;
      converter_reference          <= '0;
      samples_per_packet           <= SPP_RESET;
      sleep_sample_divider         <= DIVIDER_RESET;
      output_level_map             <= '0;
      bound_source_address         <= BIND_RESET;
      passed_sample_forward_enable <= 1'b1;
      pwm_hold_timeout             <= PWM_HOLD_RESET;
      for (int i = 0; i < HOLD_LINES; i++) begin
        line_hold[i] <= '0;
      end
    end else if (cmd.write) begin
      case (cmd.select)
        SEL_SAMPLE_INTERVAL: sample_interval <= cmd.data[15:0];
        SEL_EDGE_MASK:       edge_monitor_mask <= cmd.data[14:0]; // [R6]
        SEL_REFERENCE: begin
          if (cmd.data[1:0] <= REF_MAX && cmd.data[63:2] == '0) begin
            converter_reference <= cmd.data[1:0]; // [R7]
          end
        end
        SEL_SAMPLES_PER_PACKET: begin
          if (cmd.data[7:0] != '0) begin
            samples_per_packet <= cmd.data[7:0]; // [R8]
          end
        end
        SEL_SLEEP_DIVIDER:   sleep_sample_divider <= cmd.data[7:0];
        SEL_LEVEL_MAP:       output_level_map <= cmd.data[7:0]; // [R12]
        SEL_BOUND_ADDRESS:   bound_source_address <= cmd.data;
        SEL_FORWARD_ENABLE:  passed_sample_forward_enable <= cmd.data[0];
        SEL_LINE_HOLD: begin
          if (cmd.line < 4'(HOLD_LINES)) begin
            line_hold[cmd.line] <= cmd.data[7:0];
          end
        end
        SEL_PWM_HOLD:        pwm_hold_timeout <= cmd.data[7:0];
        default: ;
      endcase
    end
  end

  a_reference_legal: assert property (converter_reference <= REF_MAX) // [R7]
    else $error("reference select left legal range");

  // Clamp follows pin configuration changes, not only writes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      spp_effective <= SPP_RESET;
    end else if (samples_per_packet > fit_count(digital_enabled, analog_enabled)) begin
      spp_effective <= fit_count(digital_enabled, analog_enabled); // [R9]
    end else begin
      spp_effective <= samples_per_packet;
    end
  end

  a_spp_clamped: assert property (spp_effective != '0 // [R9]
    && spp_effective <= $past(samples_per_packet))
    else $error("effective batch count out of range");

  always_ff @(posedge clock) begin
    if (!rstn) begin
      param_read_data <= '0;
    end else begin
      case (cmd.select)
        SEL_SAMPLE_INTERVAL:    param_read_data <= 64'(sample_interval);
        SEL_EDGE_MASK:          param_read_data <= 64'(edge_monitor_mask);
        SEL_REFERENCE:          param_read_data <= 64'(converter_reference);
        SEL_SAMPLES_PER_PACKET: param_read_data <= 64'(spp_effective); // [R9]
        SEL_SLEEP_DIVIDER:      param_read_data <= 64'(sleep_sample_divider);
        SEL_BOUND_ADDRESS:      param_read_data <= bound_source_address;
        SEL_FORWARD_ENABLE:     param_read_data <= 64'(passed_sample_forward_enable);
        SEL_LINE_HOLD: begin
          param_read_data <= (cmd.line < 4'(HOLD_LINES)) ? 64'(line_hold[cmd.line]) : '0;
        end
        SEL_PWM_HOLD:           param_read_data <= 64'(pwm_hold_timeout);
        default:                param_read_data <= '0;
      endcase
    end
  end

  // Millisecond and hold-tick prescalers
  always_ff @(posedge clock) begin
    if (!rstn || ms_count == 18'(MS_CYCLES - 1)) begin
      ms_count <= '0;
    end else begin
      ms_count <= ms_count + 18'h1;
    end
    ms_tick <= rstn && (ms_count == 18'(MS_CYCLES - 1));
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      hold_count <= '0;
      hold_tick  <= 1'b0;
    end else if (ms_tick && hold_count == 7'(HOLD_TICK_MS - 1)) begin
      hold_count <= '0;
      hold_tick  <= 1'b1; // [R21]
    end else begin
      hold_count <= ms_tick ? hold_count + 7'h1 : hold_count;
      hold_tick  <= 1'b0;
    end
  end

  // Wake-cycle divider gates which wake periods may sample
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wake_count  <= '0;
      wake_window <= 1'b1;
    end else if (wake_start) begin
      if (sleep_sample_divider == '0 || wake_count + 8'h1 >= sleep_sample_divider) begin
        wake_count  <= '0;
        wake_window <= 1'b1; // [R10] [R11]
      end else begin
        wake_count  <= wake_count + 8'h1;
        wake_window <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || !periodic_on || !window_open) begin
      interval_count <= '0;
    end else if (ms_tick) begin
      interval_count <= periodic_fire ? '0 : interval_count + 16'h1; // [R1]
    end
  end

  // Divider zero adds one sample just before sleep
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sample_take <= 1'b0;
    end else begin
      sample_take <= periodic_fire
                     || (periodic_on && sleep_entry && sleep_sample_divider == '0); // [R11]
    end
  end

  a_periodic_off: assert property (!periodic_on |=> !sample_take) // [R2]
    else $error("sample taken while periodic sampling is off");
  a_asleep_quiet: assert property (sleep_enable && !awake && !sleep_entry |=> !sample_take) // [R10]
    else $error("periodic sample taken while asleep");

  always_ff @(posedge clock) begin
    if (!rstn) begin
      batch_count         <= '0;
      packet_send         <= 1'b0;
      packet_sample_count <= '0;
    end else if (sample_take) begin
      if (batch_count + 8'h1 >= spp_effective) begin
        batch_count         <= '0;
        packet_send         <= 1'b1; // [R8]
        packet_sample_count <= batch_count + 8'h1;
      end else begin
        batch_count <= batch_count + 8'h1;
        packet_send <= 1'b0;
      end
    end else begin
      packet_send <= 1'b0;
    end
  end

  a_packet_after_sample: assert property (packet_send |-> $past(sample_take)) // [R8]
    else $error("packet sent without a sample");

  // Edge history tracks while asleep so waking does not report stale edges
  always_ff @(posedge clock) begin
    if (!rstn) begin
      line_prev    <= '0;
      change_send  <= 1'b0;
      change_state <= '0;
    end else begin
      line_prev   <= digital_line;
      change_send <= (|next_change) && (!sleep_enable || awake); // [R3] [R5]
      if ((|next_change) && (!sleep_enable || awake)) begin
        change_state <= digital_line & digital_enabled; // [R4]
      end
    end
  end

  a_change_cause: assert property (change_send |-> // [R3]
    $past((digital_line ^ line_prev) & edge_monitor_mask) != '0)
    else $error("change sample without a masked edge");
  a_change_awake: assert property (change_send |-> $past(!sleep_enable || awake)) // [R5]
    else $error("change reported from an edge during sleep");

  always_ff @(posedge clock) begin
    if (!rstn) begin
      forward_sample <= 1'b0;
    end else begin
      forward_sample <= accept && passed_sample_forward_enable
                        && (api_mode_select == API_PLAIN || api_mode_select == API_ESCAPED); // [R15] [R16]
    end
  end

  a_forward_gate: assert property (forward_sample |-> $past(passed_sample_forward_enable) // [R16]
    && $past(api_mode_select == API_PLAIN || api_mode_select == API_ESCAPED))
    else $error("sample forwarded while forwarding disabled");

  // Hold timer zero means the passed value stays until the next sample
  always_ff @(posedge clock) begin
    if (!rstn) begin
      line_out <= '0;
      held     <= '0;
      for (int i = 0; i < HOLD_LINES; i++) begin
        hold_timer[i] <= '0;
      end
    end else begin
      for (int i = 0; i < HOLD_LINES; i++) begin
        if (!line_is_output[i]) begin
          line_out[i]   <= base_level[i];
          held[i]       <= 1'b0;
          hold_timer[i] <= '0;
        end else if (accept && rx.digital_mask[i]) begin
          line_out[i]   <= rx.digital_state[i]; // [R13]
          held[i]       <= 1'b1;
          hold_timer[i] <= line_hold[i];
        end else if (held[i] && hold_tick && hold_timer[i] != '0) begin
          hold_timer[i] <= hold_timer[i] - 8'h1; // [R17]
          if (hold_timer[i] == 8'h1) begin
            held[i]     <= 1'b0;
            line_out[i] <= base_level[i];
          end
        end else if (!held[i]) begin
          line_out[i] <= base_level[i];
        end
      end
    end
  end

  a_unbound_still: assert property (bound_source_address == BIND_DISABLED // [R14]
    && !$changed(line_is_output) && !$changed(base_level) && held == '0
    |=> line_out == $past(line_out))
    else $error("outputs moved with line passing disabled");

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pwm_duty0 <= '0;
      pwm_duty1 <= '0;
      pwm_held  <= '0;
      pwm_timer <= '0;
    end else begin
      if (accept && rx.analog0_valid && (|pwm_mode)) begin
        pwm_timer <= pwm_hold_timeout; // [R18]
      end else if (hold_tick && pwm_timer != '0) begin
        pwm_timer <= pwm_timer - 8'h1;
      end
      for (int p = 0; p < 2; p++) begin
        if (!pwm_mode[p]) begin
          pwm_held[p] <= 1'b0; // [R19]
        end else if (accept && rx.analog0_valid) begin
          pwm_held[p] <= 1'b1; // [R20]
        end else if (hold_tick && pwm_timer == 8'h1) begin
          pwm_held[p] <= 1'b0;
        end
      end
      if (accept && rx.analog0_valid && pwm_mode[0]) begin
        pwm_duty0 <= rx.analog0; // [R20]
      end else if (!pwm_mode[0] || !pwm_held[0] || (hold_tick && pwm_timer == 8'h1)) begin
        pwm_duty0 <= first_pwm_duty; // [R18]
      end
      if (accept && rx.analog0_valid && pwm_mode[1]) begin
        pwm_duty1 <= rx.analog0;
      end else if (!pwm_mode[1] || !pwm_held[1] || (hold_tick && pwm_timer == 8'h1)) begin
        pwm_duty1 <= second_pwm_duty;
      end
    end
  end

  // Sampled rstn keeps the reset-cleared duty out of the first check
  a_pwm_mode_only: assert property (rstn && !pwm_mode[0] && !$changed(first_pwm_duty) // [R19]
    ##1 !pwm_mode[0] |-> pwm_duty0 == first_pwm_duty)
    else $error("PWM0 duty not at configured value outside PWM mode");
  a_pwm_passed: assert property (accept && rx.analog0_valid && pwm_mode[1] // [R20]
    |=> pwm_duty1 == $past(rx.analog0))
    else $error("PWM1 duty not taken from received sample");

  c_periodic_packet: cover property (sample_take ##[1:4] packet_send);
  c_change_sample:   cover property (change_send);
  c_forwarded:       cover property (forward_sample);
  c_line_revert:     cover property (held[1] ##1 !held[1]);
endmodule : io_sampling_line_passing

//--- verification/remote_node.sv
`timescale 1ns/1ps
module remote_node (
  // Clock
  input  wire logic                      clock,
  // Sample handed to the device
  output io_sampling_pkg::rx_sample_type rx
);
  import io_sampling_pkg::*;

  initial rx = '0;

  // Fields are scrambled once valid drops, so a stale sample is never read as fresh
  task automatic send(input logic [63:0] src, input logic [14:0] msk, input logic [14:0] st,
                      input logic a0v, input logic [9:0] a0);
    rx_sample_type pkt;
    pkt = '{1'b1, src, msk, st, a0v, a0};
    @(posedge clock);
    rx <= pkt;
    @(posedge clock);
    pkt = ~pkt;
    pkt.valid = 1'b0;
    rx <= pkt;
  endtask : send
endmodule : remote_node

//--- verification/io_sampling_line_passing_tb.sv
`timescale 1ns/1ps
module io_sampling_line_passing_tb;
  import io_sampling_pkg::*;
  localparam int MSC   = 10;
  localparam int HOLDC = HOLD_TICK_MS * MSC;
  localparam int LIMIT = 20000;
  logic          clock, rstn, sleep_enable, awake, wake_start, sleep_entry;
  param_cmd_type cmd;
  rx_sample_type rx;
  logic [63:0]   param_read_data;
  logic [14:0]   digital_enabled, digital_line, change_state;
  logic [3:0]    analog_enabled;
  logic [12:0]   line_is_output, line_out;
  logic [12:8]   configured_high;
  logic [1:0]    pwm_mode, api_mode_select, converter_reference;
  logic [9:0]    first_pwm_duty, second_pwm_duty, pwm_duty0, pwm_duty1;
  logic          sample_take, packet_send, change_send, forward_sample;
  logic [7:0]    packet_sample_count;
  int            num_errors = 0;
  int            n_compared = 0;
  int            cycles     = 0;

  io_sampling_line_passing #(.MS_CYCLES(MSC)) dut (
    .clock(clock), .rstn(rstn), .cmd(cmd), .param_read_data(param_read_data),
    .digital_enabled(digital_enabled), .analog_enabled(analog_enabled),
    .line_is_output(line_is_output), .configured_high(configured_high),
    .digital_line(digital_line), .pwm_mode(pwm_mode), .first_pwm_duty(first_pwm_duty),
    .second_pwm_duty(second_pwm_duty), .api_mode_select(api_mode_select),
    .sleep_enable(sleep_enable), .awake(awake), .wake_start(wake_start),
    .sleep_entry(sleep_entry), .rx(rx), .sample_take(sample_take), .packet_send(packet_send),
    .packet_sample_count(packet_sample_count), .change_send(change_send),
    .change_state(change_state), .converter_reference(converter_reference),
    .forward_sample(forward_sample), .line_out(line_out), .pwm_duty0(pwm_duty0),
    .pwm_duty1(pwm_duty1));

  remote_node node (.clock(clock), .rx(rx));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic print_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // A hang would otherwise stall the run with no verdict
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input param_select_type s, input logic [3:0] ln, input logic [63:0] d);
    @(posedge clock);
    cmd <= '{1'b1, s, ln, d};
    @(posedge clock);
    cmd <= '{1'b0, s, ln, d};
  endtask : wr

  // Three cycles cover the extra stage of the clamped batch count
  task automatic rd(input param_select_type s, input logic [3:0] ln, input logic [63:0] exp);
    @(posedge clock);
    cmd <= '{1'b0, s, ln, 64'h0};
    repeat (3) @(posedge clock);
    #1 check(param_read_data, exp, "readback");
  endtask : rd

  function automatic logic pick(input int k);
    return k == 0 ? sample_take : k == 1 ? packet_send : k == 2 ? line_out[1] :
           (pwm_duty0 == first_pwm_duty);
  endfunction : pick

  task automatic wait_on(input int k, input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (pick(k) !== lvl && n < lim);
  endtask : wait_on

  task automatic flip(input logic [14:0] v);
    @(posedge clock);
    digital_line <= v;
    @(posedge clock);
    #1;
  endtask : flip

  task automatic reset_values();
    rd(SEL_SAMPLE_INTERVAL, 4'd0, 64'h0);
    rd(SEL_EDGE_MASK, 4'd0, 64'h0);
    rd(SEL_SAMPLES_PER_PACKET, 4'd0, 64'h1);
    rd(SEL_SLEEP_DIVIDER, 4'd0, 64'h1);
    rd(SEL_BOUND_ADDRESS, 4'd0, BIND_RESET);
    rd(SEL_FORWARD_ENABLE, 4'd0, 64'h1);
    rd(SEL_LINE_HOLD, 4'd12, 64'h0);
    rd(SEL_PWM_HOLD, 4'd0, 64'hFF);
  endtask : reset_values

  task automatic reference_select();
    for (int v = 0; v < 4; v++) begin
      wr(SEL_REFERENCE, 4'd0, 64'(v));
      repeat (2) @(posedge clock);
      #1 check(converter_reference, (v < 3) ? v : 2, "reference");
    end
  endtask : reference_select

  task automatic periodic();
    int n;
    @(posedge clock);
    digital_enabled <= 15'h0001;
    wr(SEL_SAMPLE_INTERVAL, 4'd0, 64'h2);
    wait_on(0, 1'b1, 100, n);
    wait_on(0, 1'b1, 100, n);
    check(n, 2 * MSC, "sample spacing");
    @(posedge clock);
    digital_enabled <= 15'h0000;
    repeat (3) @(posedge clock);
    wait_on(0, 1'b1, 60, n);
    check(sample_take, 0, "no enabled line");
  endtask : periodic

  task automatic batching();
    int n;
    @(posedge clock);
    digital_enabled <= 15'h0001;
    analog_enabled  <= 4'hF;
    wr(SEL_SAMPLES_PER_PACKET, 4'd0, 64'hFF);
    rd(SEL_SAMPLES_PER_PACKET, 4'd0, 64'd10);
    wr(SEL_SAMPLES_PER_PACKET, 4'd0, 64'h0);
    rd(SEL_SAMPLES_PER_PACKET, 4'd0, 64'd10);
    wr(SEL_SAMPLES_PER_PACKET, 4'd0, 64'h2);
    wait_on(1, 1'b1, 300, n);
    wait_on(1, 1'b1, 300, n);
    check(n, 4 * MSC, "packet spacing");
    check(packet_sample_count, 2, "packet count");
  endtask : batching

  task automatic change_detect();
    wr(SEL_EDGE_MASK, 4'd0, 64'h4001);
    rd(SEL_EDGE_MASK, 4'd0, 64'h4001);
    @(posedge clock);
    digital_enabled <= 15'h4003;
    flip(15'h0002);
    check(change_send, 0, "unmasked edge");
    flip(15'h4007);
    check(change_send, 1, "masked edge");
    check(change_state, 15'h4003, "digital state only");
  endtask : change_detect

  task automatic sleep_gating();
    int n;
    wr(SEL_SLEEP_DIVIDER, 4'd0, 64'h2);
    @(posedge clock);
    sleep_enable <= 1'b1;
    awake        <= 1'b1;
    for (int w = 0; w < 2; w++) begin
      @(posedge clock);
      wake_start <= 1'b1;
      @(posedge clock);
      wake_start <= 1'b0;
      wait_on(0, 1'b1, 40, n);
      check(sample_take, w, "wake cycle divider");
    end
    wr(SEL_SLEEP_DIVIDER, 4'd0, 64'h0);
    @(posedge clock);
    sleep_enable <= 1'b1;
    awake        <= 1'b0;
    repeat (4) @(posedge clock);
    sleep_entry <= 1'b1;
    @(posedge clock);
    sleep_entry <= 1'b0;
    #1 if (sample_take !== 1'b1) wait_on(0, 1'b1, 2, n);
    check(sample_take, 1, "sample before sleep");
    flip(15'h4006);
    check(change_send, 0, "edge while asleep");
    @(posedge clock);
    awake <= 1'b1;
    flip(15'h4007);
    check(change_send, 1, "edge while awake");
    @(posedge clock);
    sleep_enable <= 1'b0;
  endtask : sleep_gating

  task automatic line_passing();
    int n;
    @(posedge clock);
    line_is_output <= 13'h1FFF;
    wr(SEL_LEVEL_MAP, 4'd0, 64'h05);
    wr(SEL_LINE_HOLD, 4'd1, 64'h2);
    rd(SEL_LINE_HOLD, 4'd1, 64'h2);
    check(line_out, 13'h0005, "level map");
    node.send(64'h1234, 15'h0002, 15'h0002, 1'b0, 10'h0);
    #1 check(line_out, 13'h0005, "binding off");
    wr(SEL_BOUND_ADDRESS, 4'd0, 64'h1234);
    node.send(64'h1235, 15'h0002, 15'h0002, 1'b0, 10'h0);
    #1 check(line_out, 13'h0005, "other source");
    node.send(64'h1234, 15'h0002, 15'h000A, 1'b0, 10'h0);
    #1 check(line_out, 13'h0007, "bound source");
    check(forward_sample, 0, "transparent mode");
    wait_on(2, 1'b0, 2 * HOLDC + 4, n);
    check(line_out, 13'h0005, "hold revert");
    check(n >= HOLDC - 2, 1, "hold too short");
  endtask : line_passing

  task automatic forwarding();
    wr(SEL_BOUND_ADDRESS, 4'd0, BIND_ANY);
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      api_mode_select <= 2'(m);
      node.send(64'h0BAD, 15'h0001, 15'h0001, 1'b0, 10'h0);
      #1 check(forward_sample, m == 1 || m == 2, "forward by mode");
    end
    wr(SEL_FORWARD_ENABLE, 4'd0, 64'h0);
    @(posedge clock);
    api_mode_select <= API_ESCAPED;
    node.send(64'h0BAD, 15'h0001, 15'h0001, 1'b0, 10'h0);
    #1 check(forward_sample, 0, "forward disabled");
  endtask : forwarding

  task automatic pwm_passing();
    int n;
    wr(SEL_PWM_HOLD, 4'd0, 64'h2);
    @(posedge clock);
    pwm_mode <= 2'b11;
    node.send(64'h0BAD, 15'h0000, 15'h0000, 1'b1, 10'h155);
    #1 check(pwm_duty0, 10'h155, "pwm pass");
    wait_on(3, 1'b1, 2 * HOLDC + 4, n);
    check(pwm_duty0, 10'h0AA, "pwm revert");
    check(n >= HOLDC - 2, 1, "pwm hold too short");
    wr(SEL_PWM_HOLD, 4'd0, 64'h0);
    node.send(64'h0BAD, 15'h0000, 15'h0000, 1'b1, 10'h2C3);
    #1 check(pwm_duty1, 10'h2C3, "pwm1 pass");
    @(posedge clock);
    pwm_mode <= 2'b00;
    repeat (2) @(posedge clock);
    #1 check(pwm_duty0, 10'h0AA, "left pwm mode");
    check(pwm_duty1, 10'h155, "pwm1 left pwm mode");
  endtask : pwm_passing

  initial begin
    rstn            = 1'b0;
    cmd             = '0;
    digital_enabled = '0;
    analog_enabled  = '0;
    line_is_output  = '0;
    configured_high = '0;
    digital_line    = '0;
    pwm_mode        = '0;
    api_mode_select = '0;
    sleep_enable    = 1'b0;
    awake           = 1'b0;
    wake_start      = 1'b0;
    sleep_entry     = 1'b0;
    first_pwm_duty  = 10'h0AA;
    second_pwm_duty = 10'h155;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    reset_values();
    reference_select();
    periodic();
    batching();
    change_detect();
    sleep_gating();
    line_passing();
    forwarding();
    pwm_passing();
    print_verdict();
  end
endmodule : io_sampling_line_passing_tb
